//--- pmac_cfg.svh
`ifndef PMAC_CFG_SVH
`define PMAC_CFG_SVH
// register byte offsets, low address byte only
`define PMAC_OFF_MODE    8'h00
`define PMAC_OFF_STATUS  8'h04
`define PMAC_OFF_CTRL    8'h08
`define PMAC_OFF_PDC     8'h0c
`define PMAC_OFF_MIRROR  8'h10
`define PMAC_OFF_DYN     8'h14
`define PMAC_OFF_FRAM    8'h18
`define PMAC_OFF_CRAM    8'h1c
`define PMAC_OFF_SMCFG   8'h20
`define PMAC_OFF_MMU     8'h24
`define PMAC_OFF_HWOWN   8'h28
`define PMAC_OFF_COMP    8'h2c
// reset values and field positions
`define PMAC_ATTR_RST    8'h00
`define PMAC_ZERO32      32'h0000_0000
`define PMAC_CTRL_BOX    0
`define PMAC_STS_DENY    0
`define PMAC_MIRROR_EN   0
`define PMAC_PDC_LOCK    15:8
`define PMAC_MODE_IRQ    8
`define PMAC_MODE_PEND   9
`define PMAC_HSIZE_WORD  3'h2
`define PMAC_HTRANS_ACT  1
`define PMAC_RANK_TOP    2'h0
`define PMAC_RANK_SUP    2'h1
`define PMAC_RANK_APP    2'h2
`define PMAC_RANK_BAD    2'h3
`endif

//--- pmac_pkg.sv
package pmac_pkg;
	// one-hot execution modes, bit index is the mode index
	typedef enum logic [6:0] {
		PM_TOP  = 7'h01,
		PM_TOPC = 7'h02,
		PM_TOPT = 7'h04,
		PM_SUPA = 7'h08,
		PM_SUPB = 7'h10,
		PM_APPA = 7'h20,
		PM_APPB = 7'h40
	} pmac_mode_t;
	// mode-change instructions from the core
	typedef enum logic [2:0] {
		OP_NONE   = 3'h0,
		OP_LOWER  = 3'h1,
		OP_XLOWER = 3'h2,
		OP_RAISE  = 3'h3,
		OP_XRAISE = 3'h4,
		OP_ACK    = 3'h5,
		OP_INTERRUPT_RETURN_INSTR   = 3'h6
	} pmac_op_t;
	// extended-instruction handshake state
	typedef enum logic [1:0] {
		PD_IDLE = 2'h1,
		PD_WAIT = 2'h2
	} pmac_pend_t;
	typedef struct packed {
		logic       valid;
		pmac_op_t   op;
		pmac_mode_t target;
	} pmac_instr_t;
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} pmac_ap_t;
endpackage : pmac_pkg

//--- pmac_core.sv
// Function
// - security attribute registers reset to zero, the most restrictive value.
// - no mode can override the reset defaults of the attributes.
// - five memory attributes writable only from top or supervisor modes.
// - an attribute changes only from a mode with write permission for it.
// - with box policy, the dyn, fram and cram sharing attributes writable by top modes and maker code; maker code counts only in PM_SUPA.
// - lower instruction, or extended lower plus acknowledge, lowers privilege.
// - raise instruction, or extended raise plus acknowledge, raises privilege.
// - taking an interrupt switches to the interrupt's mode.
// - interrupt return restores the mode held before the interrupt.
// - security functions can be disabled and re-enabled temporarily.
// - permanent disable or enable settings can be reverted only by reset.
// - supervisor mode may write the memory management configuration.
// - application mode gets almost no configuration write access.
// - top modes hold the broadest rights, enough to configure and test.
// - foreign data segment access only when shared through attributes.
// - component registers reachable only when ownership grants the mode.
// - secure box code cannot change its own sharing rights; smcfg_r also feeds sharing and stays supervisor-writable under box policy.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pmac_cfg.svh"
module pmac_core import pmac_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire pmac_instr_t instr,
	input  wire logic        irq_take,
	input  wire pmac_mode_t  irq_mode,
	input  wire logic        maker_code,
	input  wire logic        seg_req,
	input  wire pmac_mode_t  seg_owner,
	output pmac_mode_t       cur_mode,
	output logic             in_irq,
	output logic [7:0]       sec_disable,
	output logic             seg_done,
	output logic             seg_grant
);
	pmac_mode_t  mode_r, ret_r, pend_tgt_r;
	pmac_pend_t  pend_r;
	pmac_ap_t    ap_r;
	logic        in_irq_r, pend_up_r, deny_r, rdy_r, resp_r, done_r, grant_r;
	logic [7:0]  ctrl_r, pdc_val_r, pdc_lock_r, mirror_r, dyn_r, fram_r, cram_r;
	logic [7:0]  smcfg_r, mmu_r, hwown_r, comp_r;
	logic [31:0] rdata_r, rd_val;
	logic        wr_go, wr_ok, box;
	logic [7:0]  wd, share;

	// privilege rank, lower number is more privileged
	function automatic logic [1:0] rank(input pmac_mode_t m);
		case (m)
			PM_TOP, PM_TOPC, PM_TOPT: rank = `PMAC_RANK_TOP;
			PM_SUPA, PM_SUPB:         rank = `PMAC_RANK_SUP;
			PM_APPA, PM_APPB:         rank = `PMAC_RANK_APP;
			default:                  rank = `PMAC_RANK_BAD;
		endcase
	endfunction : rank

	// index of a one-hot mode
	function automatic logic [2:0] midx(input pmac_mode_t m);
		midx = 3'h0;
		for (int i = 0; i < 7; i++) begin
			if (m[i]) begin
				midx = 3'(i);
			end
		end
	endfunction : midx

	// write permission per register and mode
	function automatic logic may_write(input logic [7:0] a, input pmac_mode_t m,
	                                   input logic mk, input logic bx);
		logic top, sup;
		top = (rank(m) == `PMAC_RANK_TOP);
		sup = (rank(m) == `PMAC_RANK_SUP);
		case (a)
			`PMAC_OFF_STATUS: may_write = 1'b1;
			`PMAC_OFF_CTRL, `PMAC_OFF_PDC: may_write = top;
			`PMAC_OFF_MIRROR, `PMAC_OFF_SMCFG, `PMAC_OFF_MMU, `PMAC_OFF_HWOWN:
				may_write = top | sup;
			`PMAC_OFF_DYN, `PMAC_OFF_FRAM, `PMAC_OFF_CRAM:
				may_write = bx ? (top | (m == PM_SUPA && mk)) : (top | sup);
			`PMAC_OFF_COMP: may_write = hwown_r[midx(m)];
			default: may_write = 1'b0;
		endcase
	endfunction : may_write

	assign box   = ctrl_r[`PMAC_CTRL_BOX];
	assign wd    = hwdata[7:0];
	assign wr_go = ap_r.valid && ap_r.write;
	assign wr_ok = may_write(ap_r.addr, mode_r, maker_code, box);
	assign share = dyn_r | fram_r | cram_r | smcfg_r;

	// read mux, component data hidden from non-owners
	always_comb begin
		rd_val = `PMAC_ZERO32;
		case (haddr[7:0])
			`PMAC_OFF_MODE:   rd_val = {22'h0, pend_r == PD_WAIT, in_irq_r, 1'b0, mode_r};
			`PMAC_OFF_STATUS: rd_val = {31'h0, deny_r};
			`PMAC_OFF_CTRL:   rd_val = {24'h0, ctrl_r};
			`PMAC_OFF_PDC:    rd_val = {16'h0, pdc_lock_r, pdc_val_r};
			`PMAC_OFF_MIRROR: rd_val = {24'h0, mirror_r};
			`PMAC_OFF_DYN:    rd_val = {24'h0, dyn_r};
			`PMAC_OFF_FRAM:   rd_val = {24'h0, fram_r};
			`PMAC_OFF_CRAM:   rd_val = {24'h0, cram_r};
			`PMAC_OFF_SMCFG:  rd_val = {24'h0, smcfg_r};
			`PMAC_OFF_MMU:    rd_val = {24'h0, mmu_r};
			`PMAC_OFF_HWOWN:  rd_val = {24'h0, hwown_r};
			`PMAC_OFF_COMP:   rd_val = hwown_r[midx(mode_r)] ? {24'h0, comp_r} : `PMAC_ZERO32;
			default:          rd_val = `PMAC_ZERO32;
		endcase
	end

	// bus address phase capture; zero wait, read data latched here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_r    <= '0;
			rdata_r <= `PMAC_ZERO32;
			rdy_r   <= 1'b1;
			resp_r  <= 1'b0;
		end else if (ce) begin
			ap_r.valid <= hsel && htrans[`PMAC_HTRANS_ACT] && hready
			              && hsize == `PMAC_HSIZE_WORD;
			ap_r.write <= hwrite;
			ap_r.addr  <= haddr[7:0];
			if (hsel && htrans[`PMAC_HTRANS_ACT] && hready && !hwrite) begin
				rdata_r <= rd_val;
			end
		end
	end

	// reset forces zero attributes; nothing else loads them
	// writes only through the permission check
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r   <= `PMAC_ATTR_RST;
			mirror_r <= `PMAC_ATTR_RST;
			dyn_r    <= `PMAC_ATTR_RST;
			fram_r   <= `PMAC_ATTR_RST;
			cram_r   <= `PMAC_ATTR_RST;
			smcfg_r  <= `PMAC_ATTR_RST;
			mmu_r    <= `PMAC_ATTR_RST;
			hwown_r  <= `PMAC_ATTR_RST;
			comp_r   <= `PMAC_ATTR_RST;
		end else if (ce && wr_go && wr_ok) begin
			case (ap_r.addr)
				`PMAC_OFF_CTRL:   ctrl_r   <= wd;
				`PMAC_OFF_MIRROR: mirror_r <= wd;
				`PMAC_OFF_DYN:    dyn_r    <= wd;
				`PMAC_OFF_FRAM:   fram_r   <= wd;
				`PMAC_OFF_CRAM:   cram_r   <= wd;
				`PMAC_OFF_SMCFG:  smcfg_r  <= wd;
				`PMAC_OFF_MMU:    mmu_r    <= wd;
				`PMAC_OFF_HWOWN:  hwown_r  <= wd;
				`PMAC_OFF_COMP:   comp_r   <= wd;
				default: ;
			endcase
		end
	end

	// disable bits; a locked bit is frozen until reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pdc_val_r  <= `PMAC_ATTR_RST;
			pdc_lock_r <= `PMAC_ATTR_RST;
		end else if (ce && wr_go && wr_ok && ap_r.addr == `PMAC_OFF_PDC) begin
			pdc_val_r  <= (pdc_lock_r & pdc_val_r) | (~pdc_lock_r & wd);
			pdc_lock_r <= pdc_lock_r | hwdata[`PMAC_PDC_LOCK];
		end
	end

	// sticky flag for refused writes; a new refusal beats the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deny_r <= 1'b0;
		end else if (ce && wr_go) begin
			if (!wr_ok) begin
				deny_r <= 1'b1;
			end else if (ap_r.addr == `PMAC_OFF_STATUS && wd[`PMAC_STS_DENY]) begin
				deny_r <= 1'b0;
			end
		end
	end

	// mode tracking; interrupt has priority over a same-cycle instruction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r     <= PM_TOP;
			ret_r      <= PM_TOP;
			pend_tgt_r <= PM_TOP;
			pend_r     <= PD_IDLE;
			pend_up_r  <= 1'b0;
			in_irq_r   <= 1'b0;
		end else if (ce) begin
			if (irq_take && rank(irq_mode) != `PMAC_RANK_BAD) begin
				// enter interrupt mode, one nesting level kept
				ret_r    <= mode_r;
				mode_r   <= irq_mode;
				in_irq_r <= 1'b1;
				pend_r   <= PD_IDLE;
			end else if (instr.valid) begin
				pend_r <= PD_IDLE;
				case (instr.op)
					OP_LOWER: if (rank(instr.target) != `PMAC_RANK_BAD
					              && rank(instr.target) > rank(mode_r)) begin
						mode_r <= instr.target;
					end
					OP_RAISE: if (rank(instr.target) < rank(mode_r)) begin
						mode_r <= instr.target;
					end
					OP_XLOWER, OP_XRAISE: begin
						pend_r     <= PD_WAIT;
						pend_tgt_r <= instr.target;
						pend_up_r  <= (instr.op == OP_XRAISE);
					end
					OP_ACK: begin
						case (pend_r)
							PD_WAIT: if (rank(pend_tgt_r) != `PMAC_RANK_BAD
							             && (pend_up_r ? rank(pend_tgt_r) < rank(mode_r)
							                           : rank(pend_tgt_r) > rank(mode_r))) begin
								mode_r <= pend_tgt_r;
							end
							default: ;
						endcase
					end
					OP_INTERRUPT_RETURN_INSTR: if (in_irq_r) begin
						mode_r   <= ret_r;
						in_irq_r <= 1'b0;
					end
					default: ;
				endcase
			end
		end
	end

	// segment check: own segment, shared, or whole view for top modes when mirror_r enable bit is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_r  <= 1'b0;
			grant_r <= 1'b0;
		end else if (ce) begin
			done_r <= seg_req;
			if (seg_req) begin
				grant_r <= (seg_owner == mode_r) || share[midx(seg_owner)]
				           || (rank(mode_r) == `PMAC_RANK_TOP && mirror_r[`PMAC_MIRROR_EN]);
			end
		end
	end

	assign hreadyout   = rdy_r;
	assign hresp       = resp_r;
	assign hrdata      = rdata_r;
	assign cur_mode    = mode_r;
	assign in_irq      = in_irq_r;
	assign sec_disable = pdc_val_r;
	assign seg_done    = done_r;
	assign seg_grant   = grant_r;

	// checks
	a_attr_reset_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		!$past(hresetn) |-> (dyn_r == 8'h00 && fram_r == 8'h00 && cram_r == 8'h00
		&& mirror_r == 8'h00 && smcfg_r == 8'h00 && pdc_val_r == 8'h00))
		else $error("attributes not zero after reset");
	a_app_no_config: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && wr_go && rank(mode_r) == `PMAC_RANK_APP && ap_r.addr != `PMAC_OFF_STATUS
		&& ap_r.addr != `PMAC_OFF_COMP)
		|=> ($stable(dyn_r) && $stable(mirror_r) && $stable(mmu_r) && $stable(ctrl_r)
		&& deny_r))
		else $error("application mode changed configuration");
	a_box_share_lock: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && wr_go && box && rank(mode_r) == `PMAC_RANK_SUP
		&& !(mode_r == PM_SUPA && maker_code)
		&& (ap_r.addr == `PMAC_OFF_DYN || ap_r.addr == `PMAC_OFF_FRAM))
		|=> ($stable(dyn_r) && $stable(fram_r)))
		else $error("box policy write let through");
	a_sup_mmu_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && wr_go && rank(mode_r) == `PMAC_RANK_SUP && ap_r.addr == `PMAC_OFF_MMU)
		|=> mmu_r == $past(hwdata[7:0]))
		else $error("supervisor mmu write lost");
	a_top_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && wr_go && rank(mode_r) == `PMAC_RANK_TOP && ap_r.addr == `PMAC_OFF_CTRL)
		|=> ctrl_r == $past(hwdata[7:0]))
		else $error("top mode write lost");
	a_pdc_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		pdc_lock_r[0] |=> (pdc_lock_r[0] && $stable(pdc_val_r[0])))
		else $error("locked disable bit reverted");
	a_lower_direct: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !irq_take && instr.valid && instr.op == OP_LOWER && mode_r == PM_TOP
		&& instr.target == PM_SUPA) |=> mode_r == PM_SUPA)
		else $error("lower instruction ignored");
	a_xraise_ack: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !irq_take && instr.valid && instr.op == OP_XRAISE && instr.target == PM_SUPA
		&& rank(mode_r) == `PMAC_RANK_APP) ##1 (ce && !irq_take && !instr.valid)
		##1 (ce && !irq_take && instr.valid && instr.op == OP_ACK) |=> mode_r == PM_SUPA)
		else $error("extended raise not applied");
	a_irq_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && irq_take && irq_mode == PM_TOP) |=> (mode_r == PM_TOP && in_irq_r))
		else $error("interrupt mode not entered");
	a_interrupt_return_instr_restore: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !irq_take && instr.valid && instr.op == OP_INTERRUPT_RETURN_INSTR && in_irq_r)
		|=> (mode_r == $past(ret_r) && !in_irq_r))
		else $error("interrupt return failed");
	a_comp_owner: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && wr_go && ap_r.addr == `PMAC_OFF_COMP && !hwown_r[midx(mode_r)])
		|=> $stable(comp_r))
		else $error("component write without ownership");
	c_irq_interrupt_return_instr: cover property (@(posedge hclk) disable iff (!hresetn)
		in_irq_r ##[1:20] !in_irq_r);
	c_deny_set: cover property (@(posedge hclk) disable iff (!hresetn) $rose(deny_r));
	c_pdc_lock: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pdc_lock_r[0]));
	c_seg_grant: cover property (@(posedge hclk) disable iff (!hresetn) seg_done && seg_grant);
endmodule : pmac_core

//--- pmac_cpu_model.sv
`timescale 1ns/1ps
module pmac_cpu_model import pmac_pkg::*; (
	input  wire logic  hclk,
	input  wire logic  seg_done,
	input  wire logic  seg_grant,
	output pmac_instr_t instr,
	output logic       irq_take,
	output pmac_mode_t irq_mode,
	output logic       maker_code,
	output logic       seg_req,
	output pmac_mode_t seg_owner
);
	// idle core at time zero, nothing issued
	initial begin
		instr      = '{valid: 1'b0, op: OP_NONE, target: PM_TOP};
		irq_take   = 1'b0;
		irq_mode   = PM_TOP;
		maker_code = 1'b0;
		seg_req    = 1'b0;
		seg_owner  = PM_TOP;
	end

	// one instruction for one cycle; valid drops so no op is taken twice
	task exec(input pmac_op_t op, input pmac_mode_t tgt);
		@(posedge hclk);
		instr <= '{valid: 1'b1, op: op, target: tgt};
		@(posedge hclk);
		instr <= '{valid: 1'b0, op: OP_NONE, target: PM_TOP};
	endtask : exec

	// interrupt entry is a single-cycle pulse
	task irq(input pmac_mode_t m);
		@(posedge hclk);
		irq_take <= 1'b1;
		irq_mode <= m;
		@(posedge hclk);
		irq_take <= 1'b0;
	endtask : irq

	// maker code flag is a level the core holds while running it
	task set_maker(input logic v);
		@(posedge hclk);
		maker_code <= v;
	endtask : set_maker

	// segment request; answer looked at in the cycle it stands
	task seg(input pmac_mode_t o, output logic [1:0] res);
		@(posedge hclk);
		seg_req   <= 1'b1;
		seg_owner <= o;
		@(posedge hclk);
		seg_req <= 1'b0;
		@(negedge hclk);
		res = {seg_done, seg_grant};
	endtask : seg
endmodule : pmac_cpu_model

//--- tb_pmac_core.sv
`timescale 1ns/1ps
`include "pmac_cfg.svh"
module tb_pmac_core import pmac_pkg::*;;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	pmac_instr_t instr;
	logic        irq_take;
	pmac_mode_t  irq_mode;
	logic        maker_code;
	logic        seg_req;
	pmac_mode_t  seg_owner;
	pmac_mode_t  cur_mode;
	logic        in_irq;
	logic [7:0]  sec_disable;
	logic        seg_done;
	logic        seg_grant;
	int          fails;
	int          samples_checked;
	logic [31:0] rd;
	logic [1:0]  sg;

	// single slave, so its hreadyout closes the hready loop
	pmac_core pmac_core_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.instr(instr), .irq_take(irq_take), .irq_mode(irq_mode), .maker_code(maker_code),
		.seg_req(seg_req), .seg_owner(seg_owner), .cur_mode(cur_mode), .in_irq(in_irq),
		.sec_disable(sec_disable), .seg_done(seg_done), .seg_grant(seg_grant));
	pmac_cpu_model pmac_cpu_model_inst (.hclk(hclk), .seg_done(seg_done), .seg_grant(seg_grant),
		.instr(instr), .irq_take(irq_take), .irq_mode(irq_mode), .maker_code(maker_code),
		.seg_req(seg_req), .seg_owner(seg_owner));

	// 10 mhz bus clock
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task end_of_test();
		if (fails == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// address phase held until hready, then data phase held until hready
	task bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= `PMAC_HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : bus_xfer

	task wr(input logic [7:0] a, input logic [31:0] wd);
		bus_xfer(1'b1, a, wd, rd);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		bus_xfer(1'b0, a, 32'h0, rd);
		check($sformatf("reg_%h", a), rd, exp);
		check("bus_resp", {30'h0, hreadyout, hresp}, 32'h0000_0002);
	endtask : rdc

	task wrc(input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp);
		wr(a, wd);
		rdc(a, exp);
	endtask : wrc

	task mode_is(input pmac_mode_t m, input logic irq);
		@(negedge hclk);
		check("mode", {24'h0, in_irq, cur_mode}, {24'h0, irq, m});
	endtask : mode_is

	task dis_is(input logic [7:0] v);
		@(negedge hclk);
		check("sec_disable", {24'h0, sec_disable}, {24'h0, v});
	endtask : dis_is

	// reset held two cycles; the bus is idle whenever this is called
	task rst_hold();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
	endtask : rst_hold

	// every mapped register comes up as zero except the mode
	task rst_chk();
		rdc(`PMAC_OFF_MODE, 32'h0000_0001);
		for (int i = 1; i < 12; i++) begin
			rdc(8'(i * 4), `PMAC_ZERO32);
		end
		dis_is(8'h00);
	endtask : rst_chk

	// hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge hclk);
		fails++;
		end_of_test();
	end

	// main sequence
	initial begin
		fails = 0;
		samples_checked = 0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = `PMAC_HSIZE_WORD;
		hwdata = 32'h0;
		rst_hold();
		rst_chk();
		wrc(`PMAC_OFF_MIRROR, 32'h1, 32'h1);
		wr(`PMAC_OFF_PDC, 32'h0003);
		dis_is(8'h03);
		wr(`PMAC_OFF_PDC, 32'h0000);
		dis_is(8'h00);
		wr(`PMAC_OFF_PDC, 32'h0101);
		wr(`PMAC_OFF_PDC, 32'h0000);
		dis_is(8'h01);
		rdc(`PMAC_OFF_PDC, 32'h0101);
		// extended lower needs its acknowledge
		pmac_cpu_model_inst.exec(OP_XLOWER, PM_APPA);
		mode_is(PM_TOP, 1'b0);
		pmac_cpu_model_inst.exec(OP_ACK, PM_APPA);
		mode_is(PM_APPA, 1'b0);
		wrc(`PMAC_OFF_MIRROR, 32'h0, 32'h1);
		rdc(`PMAC_OFF_STATUS, 32'h1);
		wrc(`PMAC_OFF_STATUS, 32'h1, 32'h0);
		wrc(`PMAC_OFF_MMU, 32'h5, 32'h0);
		wrc(`PMAC_OFF_PDC, 32'h0, 32'h0101);
		pmac_cpu_model_inst.exec(OP_XRAISE, PM_SUPA);
		pmac_cpu_model_inst.exec(OP_ACK, PM_SUPA);
		mode_is(PM_SUPA, 1'b0);
		wrc(`PMAC_OFF_MMU, 32'h5, 32'h5);
		wrc(`PMAC_OFF_SMCFG, 32'h20, 32'h20);
		pmac_cpu_model_inst.seg(PM_APPA, sg);
		check("seg_shared", {30'h0, sg}, 32'h3);
		pmac_cpu_model_inst.seg(PM_APPB, sg);
		check("seg_private", {30'h0, sg}, 32'h2);
		pmac_cpu_model_inst.irq(PM_TOP);
		mode_is(PM_TOP, 1'b1);
		pmac_cpu_model_inst.exec(OP_INTERRUPT_RETURN_INSTR, PM_TOP);
		mode_is(PM_SUPA, 1'b0);
		pmac_cpu_model_inst.exec(OP_RAISE, PM_TOP);
		mode_is(PM_TOP, 1'b0);
		// box policy narrows dyn, fram and cram sharing writes to top and maker code in PM_SUPA
		wr(`PMAC_OFF_CTRL, 32'h1);
		pmac_cpu_model_inst.exec(OP_LOWER, PM_SUPA);
		mode_is(PM_SUPA, 1'b0);
		wrc(`PMAC_OFF_FRAM, 32'h40, 32'h0);
		pmac_cpu_model_inst.set_maker(1'b1);
		wrc(`PMAC_OFF_FRAM, 32'h40, 32'h40);
		pmac_cpu_model_inst.set_maker(1'b0);
		wr(`PMAC_OFF_HWOWN, 32'h08);
		wrc(`PMAC_OFF_COMP, 32'h5a, 32'h5a);
		pmac_cpu_model_inst.exec(OP_LOWER, PM_APPA);
		mode_is(PM_APPA, 1'b0);
		rdc(`PMAC_OFF_COMP, 32'h0);
		wrc(`PMAC_OFF_COMP, 32'ha5, 32'h0);
		wrc(`PMAC_OFF_DYN, 32'h20, 32'h0);
		// second reset must undo locks and attributes alike
		rst_hold();
		rst_chk();
		end_of_test();
	end
endmodule : tb_pmac_core
